/* fpg_fan_model.sv */
// Fan PWM input model measuring pulse width and period
module fpg_fan_model (
   // Pin as seen by the fan, pulled up
   input  wire logic i_pwm,
   // Pulse width and period in ns, and count of rising edges
   output int        o_high_ns,
   output int        o_period_ns,
   output int        o_rises
);
   timeunit 1ns;
   timeprecision 1ps;
   int last_rise;
   initial begin
      last_rise = 0;
      o_high_ns = 0;
      o_period_ns = 0;
      o_rises = 0;
   end
   always @(posedge i_pwm) begin
      o_period_ns = int'($time) - last_rise;
      last_rise = int'($time);
      o_rises = o_rises + 1;
   end
   always @(negedge i_pwm) begin
      o_high_ns = int'($time) - last_rise;
   end
endmodule

/* fpg_pkg.sv */
// Constants, register map and timing of the fan PWM duty generator
package fpg_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_ENHANCED_CONFIG       = 8'h45;
   localparam logic [7:0] IDX_PWM_RPM_CONFIG        = 8'h4a;
   localparam logic [7:0] IDX_PWM_DUTY_VALUE        = 8'h4c;
   localparam logic [7:0] IDX_PWM_FREQUENCY_SETTING = 8'h4d;
   localparam logic [7:0] IDX_PWM_STATUS            = 8'h4f;
   localparam int         ADDR_W                    = 10;
   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int         HIGH_RES_PWM_ENABLE_BIT   = 4;
   localparam int         PWM_CLOCK_SELECT_BIT      = 3;
   localparam int         STAT_ACTIVE_BIT           = 0;
   localparam int         STAT_HR_MODE_BIT          = 1;
   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_ENHANCED_CONFIG       = 8'h00;
   localparam logic [7:0] RST_PWM_RPM_CONFIG        = 8'h00;
   localparam logic [7:0] RST_PWM_DUTY_VALUE        = 8'h00;
   localparam logic [7:0] RST_PWM_FREQUENCY_SETTING = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // Mode constants
   localparam logic [4:0] HR_FREQ_SETTING           = 5'h08;
   localparam logic [7:0] HR_FULL_SCALE             = 8'hff;
   localparam logic [4:0] FREQ_ZERO                 = 5'h00;
   localparam logic [4:0] FREQ_ZERO_MAPPED          = 5'h01;
   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int         CLK_HZ                    = 50_000_000;
   localparam int         FAST_CLK_HZ               = 360_000;
   localparam int         SLOW_CLK_HZ               = 1_400;
   localparam int         HR_PWM_HZ                 = 22_500;
   localparam int         HR_TICK_HZ                = HR_PWM_HZ * 255;
   localparam int         ACC_W                     = 27;
   localparam int         GAP_W                     = 17;
endpackage

/* fpg_top.sv */
// Fan PWM duty generator with register port and open-drain output
// Function
// - High resolution needs enable, fast clock, eight
// - High resolution: eight duty bits, full scale FF
// - Duty equals value over full scale count
// - Normal full scale is twice frequency field
// - Frequency is clock over twice frequency field
// - Normal mode: six duty bits, five frequency
// - Frequency field zero acts as one
module fpg_top
   import fpg_pkg::*;
#(
   parameter int P_CLK_HZ = CLK_HZ
) (
   // Clock and reset
   input  wire logic              I_CLOCK,
   input  wire logic              I_RESETN,
   // Register port
   input  wire logic [ADDR_W-1:0] I_ADDR,
   input  wire logic [31:0]       I_WDATA,
   input  wire logic              I_WR,
   input  wire logic              I_RD,
   output logic      [31:0]       O_RDATA,
   // Open-drain fan PWM pin
   output logic                   O_PWM_OUT,
   output logic                   O_PWM_OE
);

   ////////////////////////////////////////////////////////////////////////
   // Parameter check
   if (P_CLK_HZ < 2 * HR_TICK_HZ) begin : g_bad_clk
      $error("Clock too slow for the PWM tick rates");
   end

   localparam logic [ACC_W-1:0] CLK_W  = ACC_W'(P_CLK_HZ);
   localparam logic [ACC_W-1:0] INC_HR = ACC_W'(HR_TICK_HZ);
   localparam logic [ACC_W-1:0] INC_FA = ACC_W'(FAST_CLK_HZ);
   localparam logic [ACC_W-1:0] INC_SL = ACC_W'(SLOW_CLK_HZ);

   logic [7:0]       enh_cfg_q;
   logic [7:0]       rpm_cfg_q;
   logic [7:0]       duty_reg_q;
   logic [7:0]       freq_reg_q;
   logic [31:0]      rdata_q;
   logic             hr_mode;
   logic [4:0]       freq_eff;
   logic [7:0]       fs_d;
   logic [7:0]       duty_d;
   logic [7:0]       fs_q;
   logic [7:0]       duty_q;
   logic [7:0]       cnt_q;
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] inc;
   logic [ACC_W-1:0] sum;
   logic             tick;
   logic             wrap;
   logic             active;
   logic             oe_q;
   logic             wr_hit;
   logic [7:0]       idx;

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   assign idx    = I_ADDR[9:2];
   assign wr_hit = I_WR && (I_ADDR[1:0] == 2'b00);

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         enh_cfg_q  <= RST_ENHANCED_CONFIG;
         rpm_cfg_q  <= RST_PWM_RPM_CONFIG;
         duty_reg_q <= RST_PWM_DUTY_VALUE;
         freq_reg_q <= RST_PWM_FREQUENCY_SETTING;
      end else if (wr_hit) begin
         case (idx)
            IDX_ENHANCED_CONFIG:       enh_cfg_q  <= I_WDATA[7:0];
            IDX_PWM_RPM_CONFIG:        rpm_cfg_q  <= I_WDATA[7:0];
            IDX_PWM_DUTY_VALUE:        duty_reg_q <= I_WDATA[7:0];
            IDX_PWM_FREQUENCY_SETTING: freq_reg_q <= I_WDATA[7:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads, data in the following cycle
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= 32'h0000_0000;
         if (I_RD && (I_ADDR[1:0] == 2'b00)) begin
            case (idx)
               IDX_ENHANCED_CONFIG:       rdata_q[7:0] <= enh_cfg_q;
               IDX_PWM_RPM_CONFIG:        rdata_q[7:0] <= rpm_cfg_q;
               IDX_PWM_DUTY_VALUE:        rdata_q[7:0] <= duty_reg_q;
               IDX_PWM_FREQUENCY_SETTING: rdata_q[7:0] <= freq_reg_q;
               IDX_PWM_STATUS: begin
                  rdata_q[STAT_ACTIVE_BIT]  <= ~oe_q;
                  rdata_q[STAT_HR_MODE_BIT] <= hr_mode;
               end
               default: ;
            endcase
         end
      end
   end

   assign O_RDATA = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Mode and full-scale selection
   assign hr_mode  = enh_cfg_q[HIGH_RES_PWM_ENABLE_BIT] && !rpm_cfg_q[PWM_CLOCK_SELECT_BIT]
                     && (freq_reg_q[4:0] == HR_FREQ_SETTING);
   assign freq_eff = (freq_reg_q[4:0] == FREQ_ZERO) ? FREQ_ZERO_MAPPED : freq_reg_q[4:0];
   assign fs_d     = hr_mode ? HR_FULL_SCALE : {2'b00, freq_eff, 1'b0};
   assign duty_d   = hr_mode ? duty_reg_q : {2'b00, duty_reg_q[5:0]};

   ////////////////////////////////////////////////////////////////////////
   // Fractional divider for the step tick
   always_comb begin
      if (hr_mode) begin
         inc = INC_HR;
      end else if (rpm_cfg_q[PWM_CLOCK_SELECT_BIT]) begin
         inc = INC_SL;
      end else begin
         inc = INC_FA;
      end
   end

   assign sum  = acc_q + inc;
   assign tick = (sum >= CLK_W);

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         acc_q <= '0;
      end else if (tick) begin
         acc_q <= sum - CLK_W;
      end else begin
         acc_q <= sum;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Period counter, settings taken at each period end
   assign wrap = tick && (cnt_q >= fs_q - 8'h01);

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         cnt_q  <= 8'h00;
         fs_q   <= 8'h02;
         duty_q <= 8'h00;
      end else if (wrap) begin
         cnt_q  <= 8'h00;
         fs_q   <= fs_d;
         duty_q <= duty_d;
      end else if (tick) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output compare, open-drain released while active
   assign active = (cnt_q < duty_q) || (duty_q >= fs_q);

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         oe_q <= 1'b1;
      end else begin
         oe_q <= ~active;
      end
   end

   assign O_PWM_OE  = oe_q;
   assign O_PWM_OUT = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Tick spacing helper
   localparam int GAP_HR_LO = P_CLK_HZ / HR_TICK_HZ;
   localparam int GAP_FA_LO = P_CLK_HZ / FAST_CLK_HZ;
   localparam int GAP_SL_LO = P_CLK_HZ / SLOW_CLK_HZ;

   logic [GAP_W-1:0] gap_q;
   logic [ACC_W-1:0] inc_last_q;
   logic             same_q;

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         gap_q      <= '0;
         inc_last_q <= '0;
         same_q     <= 1'b0;
      end else begin
         inc_last_q <= inc;
         if (tick) begin
            gap_q  <= '0;
            same_q <= 1'b1;
         end else begin
            gap_q <= (gap_q == {GAP_W{1'b1}}) ? gap_q : gap_q + 1'b1;
            if (inc != inc_last_q) begin
               same_q <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESETN);

   AST_HR_ENTRY: assert property (hr_mode |-> (enh_cfg_q[4] && !rpm_cfg_q[3] && freq_reg_q[4:0] == 5'h08))
      else $error("High resolution mode without its three conditions");
   AST_HR_FULL: assert property (wrap && hr_mode |=> fs_q == 8'hff && duty_q == $past(duty_reg_q))
      else $error("High resolution period not taken at full scale FF");
   AST_OUT_CMP: assert property (##1 (O_PWM_OE == !$past(cnt_q < duty_q || duty_q >= fs_q)))
      else $error("Output does not follow duty compare");
   AST_NORM_FS: assert property (wrap && !hr_mode && freq_reg_q[4:0] != 5'h00
                                 |=> fs_q == {$past(freq_reg_q[4:0]), 1'b0})
      else $error("Normal full scale is not twice the frequency field");
   AST_TICK_GAP: assert property (tick && same_q && inc_last_q == inc |->
                                  ((inc == INC_HR && (gap_q + 1 == GAP_HR_LO || gap_q == GAP_HR_LO)) ||
                                   (inc == INC_FA && (gap_q + 1 == GAP_FA_LO || gap_q == GAP_FA_LO)) ||
                                   (inc == INC_SL && (gap_q + 1 == GAP_SL_LO || gap_q == GAP_SL_LO))))
      else $error("Step tick spacing wrong for the selected clock");
   AST_DUTY_LOW6: assert property (wrap && !hr_mode |=> duty_q == {2'b00, $past(duty_reg_q[5:0])})
      else $error("Normal duty not cut to six bits");
   AST_ZERO_MAP: assert property (wrap && freq_reg_q[4:0] == 5'h00 |=> fs_q == 8'h02)
      else $error("Frequency field zero not mapped to one");
   AST_FULL_ON: assert property (duty_q >= fs_q && $stable(duty_q) && $stable(fs_q) |=> !O_PWM_OE)
      else $error("Duty at full scale not held active");
   AST_CNT_RANGE: assert property (tick && cnt_q < fs_q - 8'h01 |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("Period counter failed to step");

   COV_HR_WRAP:   cover property (wrap && hr_mode);
   COV_FULL_ON:   cover property (duty_q >= fs_q ##1 !O_PWM_OE);
   COV_ZERO_FREQ: cover property (wrap && freq_reg_q[4:0] == 5'h00);
   COV_SLOW_TICK: cover property (tick && rpm_cfg_q[3] && same_q);

endmodule

/* fpg_top_bench.sv */
// Self-checking bench of the fan PWM duty generator
module fpg_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fpg_pkg::*;
   logic              clk;
   logic              rst_n;
   logic [ADDR_W-1:0] addr;
   logic [31:0]       wdata;
   logic              wr;
   logic              rd;
   logic [31:0]       rdata;
   logic              pwm_out;
   logic              pwm_oe;
   wire               pwm_line;
   int                high_ns;
   int                period_ns;
   int                rises;
   int                n_errors = 0;
   int                checks = 0;
   // Open-drain pin with pull-up
   assign pwm_line = pwm_oe ? pwm_out : 1'b1;
   fpg_top fpg_top_inst (.I_CLOCK(clk), .I_RESETN(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .O_RDATA(rdata), .O_PWM_OUT(pwm_out), .O_PWM_OE(pwm_oe));
   fpg_fan_model fpg_fan_model_inst (.i_pwm(pwm_line), .o_high_ns(high_ns), .o_period_ns(period_ns),
      .o_rises(rises));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic fail(string msg);
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic reg_wr(logic [7:0] idx, logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= {idx, 2'b00};
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic chk_reg(logic [7:0] idx, logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= {idx, 2'b00};
      @(posedge clk);
      rd <= 1'b0;
      #1;
      checks++;
      if (rdata !== exp) fail($sformatf("reg %h read %h", idx, rdata));
   endtask
   task automatic chk_lvl(logic exp, int n);
      int bad;
      bad = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         if (pwm_line !== exp) bad++;
      end
      checks++;
      if (bad != 0) fail("pin level");
   endtask
   // Wait n rises, then the next fall; compare pulse and period
   task automatic chk_pwm(int n, int hi, int per);
      int start;
      int k;
      start = rises;
      k = 0;
      while (rises < start + n && k < 60000) begin
         @(posedge clk);
         k++;
      end
      if (rises < start + n) k = 120000;
      while (pwm_line !== 1'b0 && k < 120000) begin
         @(posedge clk);
         k++;
      end
      #1;
      if (k >= 120000) begin
         fail("pwm timeout");
         wrap_up();
      end else begin
         checks++;
         if (high_ns < hi - 100 || high_ns > hi + 100 || (per > 0 && (period_ns < per - 100 || period_ns > per + 100)))
            fail($sformatf("pulse %0d ns period %0d ns", high_ns, period_ns));
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      chk_reg(IDX_ENHANCED_CONFIG, 32'h0);
      chk_reg(IDX_PWM_RPM_CONFIG, 32'h0);
      chk_reg(IDX_PWM_DUTY_VALUE, 32'h0);
      chk_reg(IDX_PWM_FREQUENCY_SETTING, 32'h0);
      chk_lvl(1'b0, 1000);
      $display("test reset done");
      reg_wr(IDX_PWM_DUTY_VALUE, 32'hffff_ff46);
      chk_reg(IDX_PWM_DUTY_VALUE, 32'h46);
      reg_wr(8'h40, 32'h55);
      chk_reg(8'h40, 32'h0);
      reg_wr(IDX_PWM_FREQUENCY_SETTING, 32'he4);
      chk_pwm(3, 16667, 22222);
      $display("test normal done");
      reg_wr(IDX_PWM_FREQUENCY_SETTING, 32'h0);
      reg_wr(IDX_PWM_DUTY_VALUE, 32'h1);
      chk_pwm(3, 2778, 5556);
      reg_wr(IDX_PWM_FREQUENCY_SETTING, 32'h2);
      reg_wr(IDX_PWM_DUTY_VALUE, 32'h4);
      repeat (1200) @(posedge clk);
      chk_lvl(1'b1, 1500);
      chk_reg(IDX_PWM_STATUS, 32'h1);
      reg_wr(IDX_PWM_FREQUENCY_SETTING, 32'h03);
      reg_wr(IDX_PWM_DUTY_VALUE, 32'h05);
      chk_pwm(3, 13889, 16667);
      $display("test scale done");
      reg_wr(IDX_ENHANCED_CONFIG, 32'h10);
      reg_wr(IDX_PWM_FREQUENCY_SETTING, 32'h08);
      reg_wr(IDX_PWM_DUTY_VALUE, 32'hbf);
      chk_pwm(3, 33290, 44444);
      chk_reg(IDX_PWM_STATUS, 32'h2);
      reg_wr(IDX_PWM_DUTY_VALUE, 32'h0c);
      chk_pwm(3, 2092, 44444);
      reg_wr(IDX_PWM_FREQUENCY_SETTING, 32'h09);
      chk_pwm(3, 33333, 50000);
      reg_wr(IDX_PWM_FREQUENCY_SETTING, 32'h08);
      reg_wr(IDX_ENHANCED_CONFIG, 32'h0);
      chk_pwm(3, 33333, 44444);
      $display("test high resolution done");
      reg_wr(IDX_PWM_FREQUENCY_SETTING, 32'h1);
      reg_wr(IDX_PWM_DUTY_VALUE, 32'h1);
      chk_pwm(3, 2778, 5556);
      // Switch in the low half, shortly before the next fast step
      repeat (120) @(posedge clk);
      reg_wr(IDX_PWM_RPM_CONFIG, 32'h08);
      chk_reg(IDX_PWM_RPM_CONFIG, 32'h08);
      chk_pwm(1, 714286, 0);
      $display("test slow clock done");
      wrap_up();
   end
endmodule
